// file: logic/dci_pkg.sv
// shared constants for the command decoder and interrupt status block
package dci_pkg;
    // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [3:0] IDX_MODE_A = 4'h0;
    localparam logic [3:0] IDX_MASKED_STATUS = 4'h2;
    localparam logic [3:0] IDX_CMD_A = 4'h2;
    localparam logic [3:0] IDX_STATUS_MASK = 4'h5;
    localparam logic [3:0] IDX_CMD_B = 4'ha;
    localparam logic [3:0] IDX_VECTOR = 4'hc;
    localparam logic [3:0] IDX_CT_START_OPSET = 4'he;
    localparam logic [3:0] IDX_CT_STOP_OPCLR = 4'hf;
    // block-local registers beyond the map, plus the 5-bit write index of command A
    localparam logic [4:0] IDX_EVENT_IN = 5'h10;
    localparam logic [4:0] IDX_CTRL_STATE = 5'h11;
    localparam logic [4:0] IDX_OUTPUT_PORT = 5'h12;
    localparam logic [4:0] IDX_CMD_A_W = 5'h02;
    localparam int ADDR_W = 7;
    // upper command nibbles
    localparam logic [3:0] CMD_STANDBY_OR_IUS = 4'hc;
    localparam logic [3:0] CMD_ACTIVE_OR_ZMODE = 4'hd;
    // reset values
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_VECTOR = 8'h0f;
    localparam logic [7:0] RST_OPR = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    // status bit positions
    localparam int BIT_TXRDY_A = 0;
    localparam int BIT_RX_A = 1;
    localparam int BIT_BRK_A = 2;
    localparam int BIT_CTR = 3;
    localparam int BIT_TXRDY_B = 4;
    localparam int BIT_RX_B = 5;
    localparam int BIT_BRK_B = 6;
    localparam int BIT_IPC = 7;
    // control state bit positions
    localparam int CTL_STANDBY = 0;
    localparam int CTL_ZMODE = 1;
    localparam int CTL_IUS = 2;
    localparam int CTL_CT_RUN = 3;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RDATA = 3'b100
    } dci_bus_e;
endpackage

// file: logic/dci_status_bit.sv
// one sticky or level-following interrupt status bit
`timescale 1ns/1ps
module dci_status_bit (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic level_mode,
    input wire logic set_evt,
    input wire logic clr_evt,
    input wire logic level_in,
    output logic bit_q
);
    typedef struct packed {
        logic bit_v;
    } dci_sb_s;
    dci_sb_s st_q;
    dci_sb_s st_d;

    // set beats clear in the same cycle
    always_comb begin
        st_d = st_q;
        if (level_mode) begin
            st_d.bit_v = level_in;
        end else if (set_evt) begin
            st_d.bit_v = 1'b1;
        end else if (clr_evt) begin
            st_d.bit_v = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bit_q = st_q.bit_v;
endmodule

// file: logic/dci_top.sv
// command decoder, address-triggered commands and interrupt status unit behind AXI4-Lite
//
// Notes on behaviour
// - nibble c on channel A enters standby
// - standby left only by reset or active
// - nibble d on channel A leaves standby
// - nibble c on B in chain mode clears in-service
// - nibble d on channel B enters chain mode
// - read of 0e starts counter, returns no data
// - start and set share 0e, stop and clear share 0f; read or write selects
// - write to 0e sets written output bits
// - output pins are complement of output register
// - request raised from eight listed sources
// - status, mask, masked status, vector at fixed addresses
// - status read at 05, write loads mask
// - masked status at 02, vector at 0c
// - status bit order input change down to tx A
// - status bit shows occurred or occurring condition
// - masked status is status and mask
// - mask one enables, zero blocks
`timescale 1ns/1ps
module dci_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [6:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [6:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic chan_a_transmit_ready,
    input wire logic chan_a_receive_ready_or_full,
    input wire logic chan_b_transmit_ready,
    input wire logic chan_b_receive_ready_or_full,
    output logic [7:0] output_pins,
    output logic interrupt_request_n,
    output logic chain_enable_out,
    output logic standby,
    output logic counter_start,
    output logic counter_stop
);
    localparam int ADDR_W_L = dci_pkg::ADDR_W;

    // state of the block in one record
    typedef struct packed {
        dci_pkg::dci_bus_e bus;
        logic [ADDR_W_L-1:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] mask;
        logic [7:0] vector;
        logic [7:0] output_port_register;
        logic standby;
        logic zmode;
        logic in_service_latch;
        logic ct_run;
        logic ct_start;
        logic ct_stop;
        logic [7:0] evt;
        logic [7:0] evt_clr;
    } dci_state_s;

    dci_state_s st_q;
    dci_state_s st_d;
    logic [7:0] status;
    logic [7:0] masked;
    logic [7:0] level_mode;
    logic [7:0] level_in;
    logic [7:0] evt_set;

    // transmit and receive bits follow their live levels, the rest are sticky events
    assign level_mode = 8'h33;
    assign level_in = {2'b00, chan_b_receive_ready_or_full, chan_b_transmit_ready,
                       2'b00, chan_a_receive_ready_or_full, chan_a_transmit_ready};

    // counter terminal count comes from software-written event register for now
    assign evt_set = st_q.evt;

    // one status bit per source
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
            dci_status_bit u_bit (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .level_mode(level_mode[gi]),
                .set_evt(evt_set[gi]),
                .clr_evt(st_q.evt_clr[gi]),
                .level_in(level_in[gi]),
                .bit_q(status[gi])
            );
        end
    endgenerate

    assign masked = status & st_q.mask;

    // register access
    function automatic logic [31:0] read_word(input logic [ADDR_W_L-1:0] a, input logic [7:0] st,
                                              input logic [7:0] ms, input dci_state_s s);
        logic [4:0] idx;
        logic [31:0] r;
        idx = a[6:2];
        r = 32'h0000_0000;
        case (idx)
            {1'b0, dci_pkg::IDX_MASKED_STATUS}: r = {24'h00_0000, ms};
            {1'b0, dci_pkg::IDX_STATUS_MASK}: r = {24'h00_0000, st};
            {1'b0, dci_pkg::IDX_VECTOR}: r = {24'h00_0000, s.vector};
            dci_pkg::IDX_CTRL_STATE: r = {28'h000_0000, s.ct_run, s.in_service_latch, s.zmode, s.standby};
            dci_pkg::IDX_OUTPUT_PORT: r = {24'h00_0000, s.output_port_register};
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [4:0] widx;
        logic [4:0] ridx;
        logic [3:0] nib;
        logic wr_go;
        st_d = st_q;
        widx = st_q.awaddr[6:2];
        ridx = s_axi_araddr[6:2];
        nib = st_q.wdata[7:4];
        wr_go = 1'b0;
        st_d.ct_start = 1'b0;
        st_d.ct_stop = 1'b0;
        st_d.evt = 8'h00;
        st_d.evt_clr = 8'h00;
        if (s_axi_awvalid && !st_q.aw_have && st_q.bus == dci_pkg::BUS_IDLE) begin
            st_d.awaddr = s_axi_awaddr;
            st_d.aw_have = 1'b1;
        end
        if (s_axi_wvalid && !st_q.w_have && st_q.bus == dci_pkg::BUS_IDLE) begin
            st_d.wdata = s_axi_wdata;
            st_d.wstrb = s_axi_wstrb;
            st_d.w_have = 1'b1;
        end
        case (st_q.bus)
            dci_pkg::BUS_IDLE: begin
                if (st_q.aw_have && st_q.w_have) begin
                    wr_go = st_q.wstrb[0];
                    st_d.aw_have = 1'b0;
                    st_d.w_have = 1'b0;
                    st_d.bresp = dci_pkg::RESP_OKAY;
                    st_d.bus = dci_pkg::BUS_WRESP;
                end else if (s_axi_arvalid) begin
                    st_d.rdata = read_word(s_axi_araddr, status, masked, st_q);
                    st_d.rresp = (ridx > dci_pkg::IDX_OUTPUT_PORT) ? dci_pkg::RESP_SLVERR : dci_pkg::RESP_OKAY;
                    if (ridx == {1'b0, dci_pkg::IDX_CT_START_OPSET}) begin
                        st_d.ct_start = 1'b1;
                        st_d.ct_run = 1'b1;
                    end
                    if (ridx == {1'b0, dci_pkg::IDX_CT_STOP_OPCLR}) begin
                        st_d.ct_stop = 1'b1;
                        st_d.ct_run = 1'b0;
                        st_d.evt_clr[dci_pkg::BIT_CTR] = 1'b1;
                    end
                    st_d.bus = dci_pkg::BUS_RDATA;
                end
            end
            dci_pkg::BUS_WRESP: begin
                if (s_axi_bready) begin
                    st_d.bus = dci_pkg::BUS_IDLE;
                end
            end
            dci_pkg::BUS_RDATA: begin
                if (s_axi_rready) begin
                    st_d.bus = dci_pkg::BUS_IDLE;
                end
            end
            default: begin
                st_d.bus = dci_pkg::BUS_IDLE;
            end
        endcase
        // write side effects
        if (wr_go) begin
            if (widx > dci_pkg::IDX_OUTPUT_PORT) begin
                st_d.bresp = dci_pkg::RESP_SLVERR;
            end
            case (widx)
                dci_pkg::IDX_CMD_A_W: begin
                    if (nib == dci_pkg::CMD_STANDBY_OR_IUS) begin
                        st_d.standby = 1'b1;
                    end else if (nib == dci_pkg::CMD_ACTIVE_OR_ZMODE) begin
                        st_d.standby = 1'b0;
                    end
                end
                {1'b0, dci_pkg::IDX_CMD_B}: begin
                    if (nib == dci_pkg::CMD_STANDBY_OR_IUS && st_q.zmode) begin
                        st_d.in_service_latch = 1'b0;
                    end else if (nib == dci_pkg::CMD_ACTIVE_OR_ZMODE) begin
                        st_d.zmode = 1'b1;
                    end
                end
                {1'b0, dci_pkg::IDX_STATUS_MASK}: st_d.mask = st_q.wdata[7:0];
                {1'b0, dci_pkg::IDX_VECTOR}: st_d.vector = st_q.wdata[7:0];
                {1'b0, dci_pkg::IDX_CT_START_OPSET}: st_d.output_port_register = st_q.output_port_register | st_q.wdata[7:0];
                {1'b0, dci_pkg::IDX_CT_STOP_OPCLR}: st_d.output_port_register = st_q.output_port_register & ~st_q.wdata[7:0];
                dci_pkg::IDX_EVENT_IN: begin
                    st_d.evt = st_q.wdata[7:0] & ~level_mode;
                end
                dci_pkg::IDX_CTRL_STATE: begin
                    st_d.evt_clr = st_q.wdata[15:8] & ~level_mode;
                    if (st_q.wdata[dci_pkg::CTL_IUS]) begin
                        st_d.in_service_latch = 1'b1;
                    end
                end
                default: begin
                    st_d.output_port_register = st_d.output_port_register;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '{bus: dci_pkg::BUS_IDLE, awaddr: '0, aw_have: 1'b0, wdata: '0, wstrb: '0,
                      w_have: 1'b0, bresp: dci_pkg::RESP_OKAY, rdata: '0, rresp: dci_pkg::RESP_OKAY,
                      mask: dci_pkg::RST_MASK, vector: dci_pkg::RST_VECTOR, output_port_register: dci_pkg::RST_OPR,
                      standby: 1'b0, zmode: 1'b0, in_service_latch: 1'b0, ct_run: 1'b0, ct_start: 1'b0,
                      ct_stop: 1'b0, evt: '0, evt_clr: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // bus handshakes
    assign s_axi_awready = (st_q.bus == dci_pkg::BUS_IDLE) && !st_q.aw_have;
    assign s_axi_wready = (st_q.bus == dci_pkg::BUS_IDLE) && !st_q.w_have;
    assign s_axi_arready = (st_q.bus == dci_pkg::BUS_IDLE) && !(st_q.aw_have && st_q.w_have);
    assign s_axi_bvalid = (st_q.bus == dci_pkg::BUS_WRESP);
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_rvalid = (st_q.bus == dci_pkg::BUS_RDATA);
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;

    // pins and block outputs
    assign output_pins = ~st_q.output_port_register;
    assign interrupt_request_n = ~(|masked);
    assign chain_enable_out = ~st_q.in_service_latch;
    assign standby = st_q.standby;
    assign counter_start = st_q.ct_start;
    assign counter_stop = st_q.ct_stop;
endmodule

// file: tb/dci_top_checker.sv
// port assertions for the command and interrupt block
`timescale 1ns/1ps
module dci_top_checker (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [6:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [6:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [7:0] output_pins,
    input wire logic interrupt_request_n,
    input wire logic chain_enable_out,
    input wire logic standby,
    input wire logic counter_start
);
    logic [4:0] aw_i;
    logic [4:0] rd_i;
    logic [7:0] wd;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // index and data of the transfers under way
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aw_i <= 5'h00;
            rd_i <= 5'h00;
            wd <= 8'h00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_i <= s_axi_awaddr[6:2];
            if (s_axi_arvalid && s_axi_arready) rd_i <= s_axi_araddr[6:2];
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
        end
    end
    AST_STBY_ON: assert property (
        $rose(s_axi_bvalid) && aw_i == 5'h02 && wd[7:4] == 4'hc |-> standby) else $error("standby not entered");
    AST_STBY_OFF: assert property (
        $rose(s_axi_bvalid) && aw_i == 5'h02 && wd[7:4] == 4'hd |-> !standby) else $error("standby not left");
    AST_STBY_HOLD: assert property (
        $changed(standby) |-> $rose(s_axi_bvalid) && aw_i == 5'h02) else $error("standby moved alone");
    AST_IUS_CLR: assert property (
        $rose(chain_enable_out) |-> $rose(s_axi_bvalid) && aw_i == 5'h0a && wd[7:4] == 4'hc)
        else $error("chain enable rose alone");
    AST_OPR_SET: assert property (
        $rose(s_axi_bvalid) && aw_i == 5'h0e |-> ~output_pins == (~$past(output_pins) | wd))
        else $error("output set wrong");
    AST_START: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 7'h38 |-> ##[1:2] counter_start)
        else $error("counter not started");
    AST_START_NODATA: assert property (
        s_axi_rvalid && rd_i == 5'h0e |-> s_axi_rdata == 32'h0) else $error("start read gave data");
    AST_MASK_ZERO: assert property (
        $rose(s_axi_bvalid) && aw_i == 5'h05 && wd == 8'h00 |-> interrupt_request_n) else $error("masked irq seen");
    AST_MASKED_IRQ: assert property (
        $rose(s_axi_rvalid) && rd_i == 5'h02 |-> (s_axi_rdata[7:0] != 8'h00) == !interrupt_request_n)
        else $error("irq disagrees with masked status");
endmodule
bind dci_top dci_top_checker dci_top_checker_i (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .output_pins(output_pins),
    .interrupt_request_n(interrupt_request_n), .chain_enable_out(chain_enable_out), .standby(standby),
    .counter_start(counter_start));

// file: tb/dci_host_model.sv
// host bus master model for the register port
`timescale 1ns/1ps
module dci_host_model (
    input wire logic clk_sys,
    output logic [6:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [6:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // response code of the last write, taken at the bvalid edge
    logic [1:0] wr_resp;
    // idle bus at time zero
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 46'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    end
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] idx, input logic [31:0] dat);
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= dat;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge clk_sys);
            if (!a_ok && s_axi_awready) begin
                a_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (!s_axi_bvalid);
        wr_resp = s_axi_bresp; // bready stays high; a next call re-drives it to the same value, so it never drops between writes
    endtask
    // read: data and response taken at the rvalid edge
    task automatic rd(input logic [4:0] idx, output logic [31:0] dat, output logic [1:0] resp);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        dat = s_axi_rdata;
        resp = s_axi_rresp; // rready stays high between reads
    endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the command and interrupt block
`timescale 1ns/1ps
module tb_top;
    logic clk_sys, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, chain_enable_out, standby;
    logic interrupt_request_n, counter_start, counter_stop;
    logic [6:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic [3:0] chan;
    logic [7:0] output_pins, output_port_register, stk, mask, st, ev;
    logic [10:0] tbl [9] = '{{5'h02, 4'hc, 2'b10}, {5'h0a, 4'hc, 2'b10}, {5'h02, 4'he, 2'b10},
        {5'h0a, 4'hd, 2'b10}, {5'h0a, 4'hf, 2'b10}, {5'h0a, 4'he, 2'b10}, {5'h02, 4'hd, 2'b00},
        {5'h0a, 4'hc, 2'b01}, {5'h02, 4'hf, 2'b01}};
    int error_cnt, checks, n_start, n_stop;
    dci_top dci_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .chan_a_transmit_ready(chan[0]), .chan_a_receive_ready_or_full(chan[1]),
        .chan_b_transmit_ready(chan[2]), .chan_b_receive_ready_or_full(chan[3]), .output_pins(output_pins),
        .interrupt_request_n(interrupt_request_n), .chain_enable_out(chain_enable_out), .standby(standby),
        .counter_start(counter_start), .counter_stop(counter_stop));
    dci_host_model host_i (.clk_sys(clk_sys), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    // value compare and register read compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [4:0] i, input logic [7:0] e);
        host_i.rd(i, rd_d, rd_r);
        chk(rd_d[7:0], e);
    endtask
    // expected status: sticky event bits plus live channel levels
    function automatic logic [7:0] exp_status(input logic [7:0] sticky, input logic [3:0] lv);
        return sticky | {2'b00, lv[3:2], 2'b00, lv[1:0]};
    endfunction
    task automatic report_and_stop();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // clock, watchdog and pulse counters
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (30000) @(posedge clk_sys);
        error_cnt++;
        report_and_stop();
    end
    always @(posedge clk_sys) begin
        n_start += int'(counter_start);
        n_stop += int'(counter_stop);
    end
    // main sequence
    initial begin
        {rst_b, chan, output_port_register, stk} = 21'h0;
        {error_cnt, checks, n_start, n_stop} = '0;
        void'($urandom(59));
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        chk({standby, chain_enable_out, interrupt_request_n, output_pins}, 11'h3ff);
        rchk(5'h0c, dci_pkg::RST_VECTOR);
        ev = 8'($urandom);
        host_i.wr(5'h0c, {24'h0, ev});
        chk(host_i.wr_resp, dci_pkg::RESP_OKAY);
        rchk(5'h0c, ev);
        host_i.rd(5'h1f, rd_d, rd_r);
        chk(rd_r, dci_pkg::RESP_SLVERR);
        host_i.wr(5'h1f, 32'h0);
        chk(host_i.wr_resp, dci_pkg::RESP_SLVERR);
        $display("test map done");
        host_i.wr(5'h11, 32'h4);
        for (int k = 0; k < 9; k++) begin
            host_i.wr(tbl[k][10:6], {24'h0, tbl[k][5:2], 4'h0});
            chk({standby, chain_enable_out}, tbl[k][1:0]);
        end
        host_i.wr(5'h02, 32'hc0);
        chk(standby, 1'b1);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        chk({standby, chain_enable_out, output_pins}, 10'h1ff);
        $display("test commands done");
        for (int k = 0; k < 10; k++) begin
            ev = (k < 2) ? 8'hff : 8'($urandom);
            output_port_register = k[0] ? (output_port_register & ~ev) : (output_port_register | ev);
            host_i.wr(k[0] ? 5'h0f : 5'h0e, {24'($urandom), ev});
            chk(output_pins, 8'(~output_port_register));
        end
        rchk(5'h12, output_port_register);
        chk(n_start, 0);
        host_i.rd(5'h0e, rd_d, rd_r);
        chk(rd_d, 32'h0);
        @(posedge clk_sys);
        chk(n_start, 1);
        $display("test output and counter done");
        for (int k = 0; k < 12; k++) begin
            chan <= 4'($urandom);
            ev = 8'($urandom);
            mask = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            host_i.wr(5'h10, {24'h0, ev});
            stk = stk | (ev & 8'hcc);
            host_i.wr(5'h05, {24'h0, mask});
            st = exp_status(stk, chan);
            rchk(5'h02, st & mask);
            rchk(5'h05, st);
            chk(interrupt_request_n, ~|(st & mask));
            if (k[1]) begin
                host_i.rd(5'h0f, rd_d, rd_r);
                stk[3] = 1'b0;
            end
            if (k[2]) begin
                host_i.wr(5'h11, 32'hcc00);
                stk = 8'h00;
            end
        end
        @(posedge clk_sys);
        chk(n_stop, 6);
        $display("test interrupts done");
        report_and_stop();
    end
endmodule
